/* File: core/fsi_indicator.sv */
/*
 * Fieldbus status indication and motion interlock of the indexer.
 * Drives the module and network status lights, checks packets moving
 * in and out over the fieldbus, and guards motion start and stop.
 * Assumes status pins are asynchronous to clk_sys_in, while packet and
 * motion command ports come from logic on the same clock.
 */
module fsi_indicator
  import fsi_pkg::*;
#(
  parameter int unsigned BLINK_CYC = BLINK_HALF_CYC,
  parameter int unsigned GAP_CYC   = PKT_GAP_CYC
) (
  // Clock and reset.
  input  wire logic               clk_sys_in,
  input  wire logic               rst_n_in,
  // Status pins from the fieldbus module and drive.
  input  wire logic [SYNC_W-1:0]  status_pins_in,
  // Packet into the device.
  input  wire logic               rx_valid_in,
  input  wire logic               rx_last_in,
  input  wire logic [WORD_W-1:0]  rx_data_in,
  // Packet out of the device.
  input  wire logic               tx_valid_in,
  input  wire logic               tx_last_in,
  input  wire logic [WORD_W-1:0]  tx_data_in,
  // Motion command.
  input  wire logic               start_in,
  input  wire logic [MOT_W-1:0]   start_index_in,
  input  wire logic [15:0]        distance_in,
  input  wire logic [15:0]        speed_in,
  input  wire logic [DWELL_W-1:0] dwell_cyc_in,
  input  wire logic               move_done_in,
  // Status lights.
  output logic                    module_green_out,
  output logic                    module_red_out,
  output logic                    network_green_out,
  output logic                    network_red_out,
  // Link mode.
  output logic                    link_up_out,
  output logic                    link_100_out,
  output logic                    link_full_out,
  // Packet words passed on.
  output logic                    rx_word_valid_out,
  output logic [WORD_W-1:0]       rx_word_out,
  output logic [PKT_CNT_W-1:0]    rx_index_out,
  output logic                    rx_overflow_out,
  output logic                    tx_word_valid_out,
  output logic [WORD_W-1:0]       tx_word_out,
  output logic [PKT_CNT_W-1:0]    tx_index_out,
  output logic                    tx_overflow_out,
  output logic                    rate_violation_out,
  // Motion state and display.
  output logic                    motion_active_out,
  output logic                    motion_refused_out,
  output logic                    motion_abort_out,
  output logic [15:0]             motion_velocity_out,
  output logic                    velocity_reduced_out,
  output logic [MOT_W-1:0]        display_motion_out,
  output logic                    display_enable_dp_out
);

  // Maps a light state and the blink phase onto the green and red lamps.
  function automatic logic [1:0] light_drive(fsi_light_e l, logic ph);
    case (l)
      FSI_LIGHT_GREEN:       light_drive = 2'h2;
      FSI_LIGHT_GREEN_FLASH: light_drive = {ph, 1'b0};
      FSI_LIGHT_RED:         light_drive = 2'h1;
      FSI_LIGHT_RED_FLASH:   light_drive = {1'b0, ph};
      default:               light_drive = 2'h0;
    endcase
  endfunction

  // Three-stage synchroniser; a change counts once stages two and three
  // agree, which also filters a single-cycle glitch on a pin.
  logic [SYNC_W-1:0] sy1, sy2, sy3, st;
  logic [SYNC_W-1:0] next_st;

  always_comb begin
    next_st = (sy2 & sy3) | (st & (sy2 ^ sy3));
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sy1 <= '0;
      sy2 <= '0;
      sy3 <= '0;
      st  <= '0;
    end else begin
      sy1 <= status_pins_in;
      sy2 <= sy1;
      sy3 <= sy2;
      st  <= next_st;
    end
  end

  // Blink prescaler.
  logic [BLINK_CNT_W-1:0] blink_cnt, next_blink_cnt;
  logic                   phase, next_phase;

  always_comb begin
    next_blink_cnt = blink_cnt + 1'b1;
    next_phase     = phase;
    if (blink_cnt == BLINK_CNT_W'(BLINK_CYC - 1)) begin
      next_blink_cnt = '0;
      next_phase     = !phase;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      blink_cnt <= '0;
      phase     <= 1'b0;
    end else begin
      blink_cnt <= next_blink_cnt;
      phase     <= next_phase;
    end
  end

  // Status lights and link mode.
  fsi_light_e mod_light, net_light;
  logic [1:0] next_mod, next_net;
  logic [2:0] next_link;

  always_comb begin
    mod_light = FSI_LIGHT_OFF;
    net_light = FSI_LIGHT_OFF;
    if (st[SY_POWER]) begin
      if (st[SY_MAJOR_FAULT])
        mod_light = FSI_LIGHT_RED;
      else if (st[SY_RECOV_FAULT])
        mod_light = FSI_LIGHT_RED_FLASH;
      else if (st[SY_CONFIGURED] && st[SY_SCAN_RUN] && !st[SY_SCAN_IDLE])
        mod_light = FSI_LIGHT_GREEN;
      else
        mod_light = FSI_LIGHT_GREEN_FLASH;
      if (st[SY_IP_ASSIGNED]) begin
        if (st[SY_DUP_IP] || st[SY_FATAL])
          net_light = FSI_LIGHT_RED;
        else if (st[SY_CONN_TIMEOUT])
          net_light = FSI_LIGHT_RED_FLASH;
        else if (st[SY_CONN_UP])
          net_light = FSI_LIGHT_GREEN;
        else
          net_light = FSI_LIGHT_GREEN_FLASH;
      end
    end
    next_mod  = light_drive(mod_light, phase);
    next_net  = light_drive(net_light, phase);
    next_link = {st[SY_LINK_UP], st[SY_LINK_UP] & st[SY_LINK_100],
                 st[SY_LINK_UP] & st[SY_LINK_FULL]};
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {module_green_out, module_red_out}   <= 2'h0;
      {network_green_out, network_red_out} <= 2'h0;
      {link_up_out, link_100_out, link_full_out} <= 3'h0;
    end else begin
      {module_green_out, module_red_out}   <= next_mod;
      {network_green_out, network_red_out} <= next_net;
      {link_up_out, link_100_out, link_full_out} <= next_link;
    end
  end

  // Packet word counters, index 0 inbound and 1 outbound. Words past the
  // limit are dropped rather than wrapped so the map stays aligned.
  logic                 pk_valid [2];
  logic                 pk_last  [2];
  logic [WORD_W-1:0]    pk_data  [2];
  logic [PKT_CNT_W-1:0] pk_cnt   [2];
  logic                 pk_ovf   [2];
  logic                 pk_wv    [2];
  logic [WORD_W-1:0]    pk_word  [2];
  logic [PKT_CNT_W-1:0] pk_idx   [2];

  assign pk_valid[0] = rx_valid_in;
  assign pk_last[0]  = rx_last_in;
  assign pk_data[0]  = rx_data_in;
  assign pk_valid[1] = tx_valid_in;
  assign pk_last[1]  = tx_last_in;
  assign pk_data[1]  = tx_data_in;

  for (genvar k = 0; k < 2; k++) begin : g_pkt
    logic [PKT_CNT_W-1:0] next_cnt, next_idx;
    logic                 next_ovf, next_wv;
    logic [WORD_W-1:0]    next_word;

    always_comb begin
      next_cnt  = pk_cnt[k];
      next_idx  = pk_idx[k];
      next_word = pk_word[k];
      next_wv   = 1'b0;
      next_ovf  = 1'b0;
      if (pk_valid[k]) begin
        if (pk_cnt[k] < PKT_MAX_WORDS) begin
          next_wv   = 1'b1;
          next_word = pk_data[k];
          next_idx  = pk_cnt[k];
          next_cnt  = pk_cnt[k] + 1'b1;
        end else begin
          next_ovf  = 1'b1;
        end
        if (pk_last[k])
          next_cnt = '0;
      end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        pk_cnt[k]  <= '0;
        pk_idx[k]  <= '0;
        pk_word[k] <= '0;
        pk_wv[k]   <= 1'b0;
        pk_ovf[k]  <= 1'b0;
      end else begin
        pk_cnt[k]  <= next_cnt;
        pk_idx[k]  <= next_idx;
        pk_word[k] <= next_word;
        pk_wv[k]   <= next_wv;
        pk_ovf[k]  <= next_ovf;
      end
    end
  end

  assign rx_word_valid_out = pk_wv[0];
  assign rx_word_out       = pk_word[0];
  assign rx_index_out      = pk_idx[0];
  assign rx_overflow_out   = pk_ovf[0];
  assign tx_word_valid_out = pk_wv[1];
  assign tx_word_out       = pk_word[1];
  assign tx_index_out      = pk_idx[1];
  assign tx_overflow_out   = pk_ovf[1];

  // Inbound packet spacing. The scanner owns the pace; an early packet is
  // still taken, only flagged, since dropping it would lose commands.
  logic [GAP_CNT_W-1:0] gap_cnt, next_gap_cnt;
  logic                 next_rate;
  logic                 rx_first;

  always_comb begin
    rx_first     = rx_valid_in && (pk_cnt[0] == '0);
    next_gap_cnt = gap_cnt;
    if (gap_cnt != GAP_CNT_W'(GAP_CYC - 1))
      next_gap_cnt = gap_cnt + 1'b1;
    next_rate = rx_first && (gap_cnt != GAP_CNT_W'(GAP_CYC - 1));
    if (rx_first)
      next_gap_cnt = '0;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_cnt            <= GAP_CNT_W'(GAP_CYC - 1);
      rate_violation_out <= 1'b0;
    end else begin
      gap_cnt            <= next_gap_cnt;
      rate_violation_out <= next_rate;
    end
  end

  // Motion sequencer.
  fsi_mot_e             mot, next_mot;
  logic [DWELL_W-1:0]   dwell, next_dwell;
  logic [MOT_W-1:0]     next_disp;
  logic [15:0]          next_vel;
  logic                 next_red, next_ref, next_abort;
  logic                 may_run;

  always_comb begin
    next_mot   = mot;
    next_dwell = dwell;
    next_disp  = display_motion_out;
    next_vel   = motion_velocity_out;
    next_red   = velocity_reduced_out;
    next_ref   = 1'b0;
    next_abort = 1'b0;
    // enabled and fault free; warnings ignored
    may_run    = st[SY_ENABLE] && !st[SY_FAULT];
    case (mot)
      FSI_MOT_IDLE: begin
        if (start_in) begin
          if (may_run && start_index_in <= MOTION_LAST) begin
            next_mot  = FSI_MOT_MOVE;
            next_disp = start_index_in;
            next_red  = distance_in < speed_in;
            next_vel  = next_red ? distance_in : speed_in;
          end else begin
            next_ref  = 1'b1;
          end
        end
      end
      FSI_MOT_MOVE: begin
        next_ref = start_in;
        if (!may_run) begin
          next_mot   = FSI_MOT_IDLE;
          next_abort = 1'b1;
        end else if (move_done_in) begin
          next_dwell = dwell_cyc_in;
          next_mot   = (dwell_cyc_in == '0) ? FSI_MOT_IDLE : FSI_MOT_DWELL;
        end
      end
      FSI_MOT_DWELL: begin
        next_ref   = start_in;
        next_dwell = dwell - 1'b1;
        if (dwell == DWELL_W'(1))
          next_mot = FSI_MOT_IDLE;
      end
      default: next_mot = FSI_MOT_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mot                  <= FSI_MOT_IDLE;
      dwell                <= '0;
      display_motion_out   <= '0;
      motion_velocity_out  <= '0;
      velocity_reduced_out <= 1'b0;
      motion_refused_out   <= 1'b0;
      motion_abort_out     <= 1'b0;
    end else begin
      mot                  <= next_mot;
      dwell                <= next_dwell;
      display_motion_out   <= next_disp;
      motion_velocity_out  <= next_vel;
      velocity_reduced_out <= next_red;
      motion_refused_out   <= next_ref;
      motion_abort_out     <= next_abort;
    end
  end

  assign motion_active_out     = (mot != FSI_MOT_IDLE);
  assign display_enable_dp_out = st[SY_ENABLE];

  a_busy_refuses_start: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (motion_active_out && start_in) |=> motion_refused_out)
    else $error("start accepted while motion busy");

  a_disabled_no_start: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (!motion_active_out && start_in && !st[SY_ENABLE])
      |=> !motion_active_out && motion_refused_out)
    else $error("motion started while disabled");

  a_fault_aborts_move: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (mot == FSI_MOT_MOVE && st[SY_FAULT])
      |=> motion_abort_out && !motion_active_out)
    else $error("fault did not stop the move");

  a_velocity_capped: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (!motion_active_out && start_in && may_run &&
     start_index_in <= MOTION_LAST && distance_in < speed_in)
      |=> velocity_reduced_out && motion_velocity_out == $past(distance_in))
    else $error("short move not slowed");

  a_major_red_steady: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (st[SY_POWER] && st[SY_MAJOR_FAULT])[*2]
      |=> module_red_out && !module_green_out)
    else $error("major fault light not steady red");

  a_net_off_unaddressed: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    !st[SY_IP_ASSIGNED] |=> !network_green_out && !network_red_out)
    else $error("network light lit without address");

  a_rx_limit_held: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (rx_valid_in && pk_cnt[0] == PKT_MAX_WORDS)
      |=> rx_overflow_out && !rx_word_valid_out)
    else $error("inbound word past limit accepted");

  a_tx_limit_held: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (tx_valid_in && pk_cnt[1] == PKT_MAX_WORDS)
      |=> tx_overflow_out && !tx_word_valid_out)
    else $error("outbound word past limit accepted");

  a_index_in_range: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    rx_index_out < PKT_MAX_WORDS && tx_index_out < PKT_MAX_WORDS)
    else $error("packet word index out of range");

  a_blink_half_duty: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    $changed(phase) |-> $past(blink_cnt) == BLINK_CNT_W'(BLINK_CYC - 1))
    else $error("blink phase toggled off cadence");

  a_run_green_steady: assert property (
    @(posedge clk_sys_in) disable iff (!rst_n_in)
    (st[SY_POWER] && st[SY_CONFIGURED] && st[SY_SCAN_RUN] &&
     !st[SY_SCAN_IDLE] && !st[SY_MAJOR_FAULT] && !st[SY_RECOV_FAULT])
      |=> module_green_out && !module_red_out)
    else $error("run state light not steady green");

endmodule

/* File: core/fsi_pkg.sv */
/*
 * Shared constants and types for the fieldbus status indication block:
 * clock rate, blink cadence, packet limits, motion range and the layout
 * of the synchronised status vector.
 * Assumes a single 100 MHz system clock.
 */
package fsi_pkg;

  // Clock rate and time figures.
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned BLINK_HALF_MS   = 500;
  localparam int unsigned BLINK_HALF_CYC  = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int unsigned PKT_GAP_MS      = 1;
  localparam int unsigned PKT_GAP_CYC     = CLK_HZ / 1000 * PKT_GAP_MS;
  localparam int unsigned BLINK_CNT_W     = 26;
  localparam int unsigned GAP_CNT_W       = 17;

  // Packet exchange.
  localparam int unsigned WORD_W          = 16;
  localparam int unsigned PKT_CNT_W       = 7;
  localparam logic [6:0]  PKT_MAX_WORDS   = 7'h78;

  // Motion table and dwell.
  localparam int unsigned MOT_W           = 6;
  localparam logic [5:0]  MOTION_LAST     = 6'h20;
  localparam int unsigned DWELL_W         = 16;

  // Bit positions in the synchronised status vector.
  localparam int unsigned SY_POWER        = 0;
  localparam int unsigned SY_CONFIGURED   = 1;
  localparam int unsigned SY_SCAN_RUN     = 2;
  localparam int unsigned SY_SCAN_IDLE    = 3;
  localparam int unsigned SY_MAJOR_FAULT  = 4;
  localparam int unsigned SY_RECOV_FAULT  = 5;
  localparam int unsigned SY_IP_ASSIGNED  = 6;
  localparam int unsigned SY_CONN_UP      = 7;
  localparam int unsigned SY_DUP_IP       = 8;
  localparam int unsigned SY_FATAL        = 9;
  localparam int unsigned SY_CONN_TIMEOUT = 10;
  localparam int unsigned SY_LINK_UP      = 11;
  localparam int unsigned SY_LINK_100     = 12;
  localparam int unsigned SY_LINK_FULL    = 13;
  localparam int unsigned SY_ENABLE       = 14;
  localparam int unsigned SY_FAULT        = 15;
  localparam int unsigned SY_WARNING      = 16;
  localparam int unsigned SYNC_W          = 17;

  typedef enum {
    FSI_LIGHT_OFF,
    FSI_LIGHT_GREEN,
    FSI_LIGHT_GREEN_FLASH,
    FSI_LIGHT_RED,
    FSI_LIGHT_RED_FLASH
  } fsi_light_e;

  typedef enum {
    FSI_MOT_IDLE,
    FSI_MOT_MOVE,
    FSI_MOT_DWELL
  } fsi_mot_e;

endpackage

/* File: testbench/fsi_indicator_tb.sv */
/*
 * Self-checking bench for the status lights, packet checks and motion
 * interlocks. Assumes short blink and gap parameters for simulation.
 */
`define CHK(nm, got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("mismatch %s expected %0h seen %0h", nm, exp, got); \
  end end
module fsi_indicator_tb
  import fsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned GAP = 20;
  localparam logic [SYNC_W-1:0] EN = 17'h04001;
  logic              clk_sys_in = 1'b0;
  logic              rst_n_in = 1'b0;
  logic [SYNC_W-1:0] status_pins_in = '0;
  logic              rx_valid_in, rx_last_in;
  logic [WORD_W-1:0] rx_data_in;
  logic              tx_valid_in = 1'b0, tx_last_in = 1'b0;
  logic [WORD_W-1:0] tx_data_in = '0;
  logic              start_in = 1'b0, move_done_in = 1'b0;
  logic [MOT_W-1:0]  start_index_in = '0;
  logic [15:0]       distance_in = '0, speed_in = '0, dwell_cyc_in = '0;
  logic              module_green_out, module_red_out, network_green_out;
  logic              network_red_out, link_up_out, link_100_out, link_full_out;
  logic              rx_word_valid_out, rx_overflow_out, tx_word_valid_out;
  logic              tx_overflow_out, rate_violation_out, motion_active_out;
  logic              motion_refused_out, motion_abort_out;
  logic              display_enable_dp_out, velocity_reduced_out;
  logic [WORD_W-1:0] rx_word_out, tx_word_out;
  logic [PKT_CNT_W-1:0] rx_index_out, tx_index_out;
  logic [15:0]       motion_velocity_out;
  logic [MOT_W-1:0]  display_motion_out;
  int                n_mismatch = 0, tests_run = 0;
  int                n_rx, n_rxo, n_tx, n_txo, n_rate, n_abort;
  integer            seed = 32'h268300f9;
  logic [SYNC_W-1:0] corner [7] = '{17'h00000, 17'h038c7, 17'h00841,
    17'h04151, 17'h02c61, 17'h002cb, 17'h018c1};

  fsi_indicator #(.BLINK_CYC(8), .GAP_CYC(GAP)) i_fsi_indicator (
    .clk_sys_in, .rst_n_in, .status_pins_in, .rx_valid_in, .rx_last_in,
    .rx_data_in, .tx_valid_in, .tx_last_in, .tx_data_in, .start_in,
    .start_index_in, .distance_in, .speed_in, .dwell_cyc_in, .move_done_in,
    .module_green_out, .module_red_out, .network_green_out, .network_red_out,
    .link_up_out, .link_100_out, .link_full_out, .rx_word_valid_out,
    .rx_word_out, .rx_index_out, .rx_overflow_out, .tx_word_valid_out,
    .tx_word_out, .tx_index_out, .tx_overflow_out, .rate_violation_out,
    .motion_active_out, .motion_refused_out, .motion_abort_out,
    .motion_velocity_out, .velocity_reduced_out, .display_motion_out,
    .display_enable_dp_out);

  fsi_scanner_model #(.GAP(GAP)) i_fsi_scanner_model (
    .clk_in(clk_sys_in), .valid_out(rx_valid_in), .last_out(rx_last_in),
    .data_out(rx_data_in));

  always #5 clk_sys_in = ~clk_sys_in;

  function automatic logic [15:0] pat(int i);
    return 16'(i) * 16'h0123 ^ 16'ha5a5;
  endfunction

  function automatic fsi_light_e exp_mod(logic [SYNC_W-1:0] p);
    if (!p[SY_POWER]) return FSI_LIGHT_OFF;
    if (p[SY_MAJOR_FAULT]) return FSI_LIGHT_RED;
    if (p[SY_RECOV_FAULT]) return FSI_LIGHT_RED_FLASH;
    if (p[SY_CONFIGURED] && p[SY_SCAN_RUN] && !p[SY_SCAN_IDLE])
      return FSI_LIGHT_GREEN;
    return FSI_LIGHT_GREEN_FLASH;
  endfunction

  function automatic fsi_light_e exp_net(logic [SYNC_W-1:0] p);
    if (!p[SY_POWER] || !p[SY_IP_ASSIGNED]) return FSI_LIGHT_OFF;
    if (p[SY_DUP_IP] || p[SY_FATAL]) return FSI_LIGHT_RED;
    if (p[SY_CONN_TIMEOUT]) return FSI_LIGHT_RED_FLASH;
    if (p[SY_CONN_UP]) return FSI_LIGHT_GREEN;
    return FSI_LIGHT_GREEN_FLASH;
  endfunction

  // Over a 20-cycle window a flashing lamp is lit only part of the time.
  function automatic fsi_light_e obs(int g, int r);
    if (g == 0 && r == 0) return FSI_LIGHT_OFF;
    if (g == 20) return FSI_LIGHT_GREEN;
    if (r == 20) return FSI_LIGHT_RED;
    if (r == 0) return FSI_LIGHT_GREEN_FLASH;
    return FSI_LIGHT_RED_FLASH;
  endfunction

  task automatic give_verdict();
    if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk_sys_in) begin
    if (rx_word_valid_out === 1'b1) begin
      `CHK("rx_index", rx_index_out, 7'(n_rx))
      `CHK("rx_word", rx_word_out, pat(n_rx))
      n_rx++;
    end
    if (tx_word_valid_out === 1'b1) begin
      `CHK("tx_index", tx_index_out, 7'(n_tx))
      `CHK("tx_word", tx_word_out, pat(n_tx))
      n_tx++;
    end
    n_rxo += (rx_overflow_out === 1'b1);
    n_txo += (tx_overflow_out === 1'b1);
    n_rate += (rate_violation_out === 1'b1);
    n_abort += (motion_abort_out === 1'b1);
  end

  // The pins pass a synchroniser, so give them time to land.
  task automatic settle(input logic [SYNC_W-1:0] p);
    status_pins_in = p;
    repeat (8) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic lights(input logic [SYNC_W-1:0] p);
    int gm, rm, gn, rn;
    logic [2:0] lk;
    gm = 0;
    rm = 0;
    gn = 0;
    rn = 0;
    lk = {p[SY_LINK_UP], p[SY_LINK_100] & p[SY_LINK_UP],
          p[SY_LINK_FULL] & p[SY_LINK_UP]};
    settle(p);
    repeat (20) begin
      gm += module_green_out;
      rm += module_red_out;
      gn += network_green_out;
      rn += network_red_out;
      @(posedge clk_sys_in);
      #1;
    end
    `CHK("module_light", obs(gm, rm), exp_mod(p))
    `CHK("network_light", obs(gn, rn), exp_net(p))
    `CHK("mixed_colour", gm * rm + gn * rn, 0)
    `CHK("link", {link_up_out, link_100_out, link_full_out}, lk)
    `CHK("enable_dp", display_enable_dp_out, p[SY_ENABLE])
  endtask

  // Each start pulse is followed by an idle edge, so a second call never
  // raises the strobe in the same step that lowered it.
  task automatic mstart(input logic [5:0] idx, input bit ok);
    logic [15:0] d, s;
    d = 16'($random(seed));
    s = (idx == 6'h20) ? d : 16'($random(seed));
    start_index_in = idx;
    distance_in = d;
    speed_in = s;
    start_in = 1'b1;
    @(posedge clk_sys_in);
    #1;
    start_in = 1'b0;
    `CHK("refused", motion_refused_out, 1'(!ok))
    if (ok) begin
      `CHK("active", motion_active_out, 1'b1)
      `CHK("display", display_motion_out, idx)
      `CHK("velocity", motion_velocity_out, (d < s) ? d : s)
      `CHK("reduced", velocity_reduced_out, 1'(d < s))
    end
    @(posedge clk_sys_in);
    #1;
  endtask

  task automatic done(input logic [15:0] dw);
    int n;
    dwell_cyc_in = dw;
    move_done_in = 1'b1;
    @(posedge clk_sys_in);
    #1;
    move_done_in = 1'b0;
    if (dw != 0)
      mstart(6'h09, 1'b0);
    n = 0;
    while (motion_active_out !== 1'b0) begin
      n++;
      if (n > 50) begin
        n_mismatch++;
        give_verdict();
      end
      @(posedge clk_sys_in);
      #1;
    end
  endtask

  task automatic pkt(input bit tx, input int len, input bit early);
    int n;
    n_rx = 0;
    n_rxo = 0;
    n_tx = 0;
    n_txo = 0;
    if (!tx) begin
      i_fsi_scanner_model.send(len, early);
    end else begin
      for (int i = 0; i < len; i++) begin
        tx_valid_in = 1'b1;
        tx_last_in = (i == len - 1);
        tx_data_in = pat(i);
        @(posedge clk_sys_in);
        #1;
      end
      tx_valid_in = 1'b0;
      tx_last_in = 1'b0;
      tx_data_in = ~tx_data_in;
    end
    repeat (2) @(posedge clk_sys_in);
    #1;
    n = (len > int'(PKT_MAX_WORDS)) ? int'(PKT_MAX_WORDS) : len;
    `CHK("words", tx ? n_tx : n_rx, n)
    `CHK("overflows", tx ? n_txo : n_rxo, len - n)
  endtask

  initial begin
    #500_000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    logic [SYNC_W-1:0] p;
    repeat (16) @(posedge clk_sys_in);
    #1;
    rst_n_in = 1'b1;
    for (int k = 0; k < 19; k++) begin
      p = (k < 7) ? corner[k] : SYNC_W'($random(seed));
      if (k >= 7)
        p[SY_POWER] = (k % 3 != 0);
      lights(p);
    end
    n_abort = 0;
    settle(EN);
    mstart(6'h05, 1'b1);
    mstart(6'h06, 1'b0);
    done(16'h0003);
    mstart(6'h20, 1'b1);
    settle(EN | 17'h10000);
    `CHK("warn_active", motion_active_out, 1'b1)
    settle(EN | 17'h08000);
    `CHK("abort", n_abort, 1)
    `CHK("stopped", motion_active_out, 1'b0)
    mstart(6'h01, 1'b0);
    settle(EN);
    mstart(6'h21, 1'b0);
    mstart(6'h00, 1'b1);
    done(16'h0000);
    settle(17'h00001);
    mstart(6'h02, 1'b0);
    pkt(1'b0, 120, 1'b0);
    pkt(1'b0, 121, 1'b0);
    pkt(1'b0, 1, 1'b0);
    pkt(1'b1, 120, 1'b0);
    pkt(1'b1, 121, 1'b0);
    n_rate = 0;
    pkt(1'b0, 2, 1'b0);
    pkt(1'b0, 2, 1'b1);
    `CHK("rate_early", n_rate, 1)
    pkt(1'b0, 2, 1'b0);
    `CHK("rate_paced", n_rate, 1)
    // A reset in mid-move must drop the motion and clear the display.
    settle(EN);
    mstart(6'h03, 1'b1);
    rst_n_in = 1'b0;
    #1;
    `CHK("rst_active", motion_active_out, 1'b0)
    `CHK("rst_display", display_motion_out, 6'h00)
    repeat (2) @(posedge clk_sys_in);
    #1;
    rst_n_in = 1'b1;
    settle(EN);
    mstart(6'h04, 1'b1);
    done(16'h0000);
    give_verdict();
  end
endmodule

/* File: testbench/fsi_scanner_model.sv */
/*
 * Behavioural model of the network scanner that starts inbound packets.
 * Assumes it is called from the bench just after a rising clock edge.
 */
module fsi_scanner_model
  import fsi_pkg::*;
#(
  parameter int unsigned GAP = 20
) (
  // Clock.
  input  wire logic              clk_in,
  // Inbound packet words.
  output logic                   valid_out,
  output logic                   last_out,
  output logic [WORD_W-1:0]      data_out
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned since = GAP + 2;

  initial begin
    valid_out = 1'b0;
    last_out  = 1'b0;
    data_out  = '0;
  end

  always @(posedge clk_in) begin
    since <= since + 1;
  end

  // Words sent whole; an early packet only when asked.
  task automatic send(input int len, input bit early);
    while (!early && since < GAP + 2) begin
      @(posedge clk_in);
      #1;
    end
    since = 0;
    for (int i = 0; i < len; i++) begin
      valid_out = 1'b1;
      last_out  = (i == len - 1);
      data_out  = 16'(i) * 16'h0123 ^ 16'ha5a5;
      @(posedge clk_in);
      #1;
    end
    valid_out = 1'b0;
    last_out  = 1'b0;
    // A released data line must not keep showing the last word.
    data_out  = ~data_out;
  endtask
endmodule
